//--- fvrc_pkg.sv
// package: register map, field positions, gain codes, timing for the fixed reference control
package fvrc_pkg;

    // wishbone byte offsets
    localparam logic [3:0] FVRC_CTRL_OFS   = 4'h0;  // fixed_ref_control
    localparam logic [3:0] FVRC_STAT_OFS   = 4'h4;  // sticky event status (read only)
    localparam logic [3:0] FVRC_CLR_OFS    = 4'h8;  // status clear (write one)
    localparam logic [3:0] FVRC_IEN_OFS    = 4'hc;  // interrupt enable

    // fixed_ref_control field positions
    localparam int FVRC_EN_BIT    = 7;
    localparam int FVRC_RDY_BIT   = 6;
    localparam int FVRC_TEMP_INDICATOR_ENABLE_BIT  = 5;
    localparam int FVRC_TEMP_RANGE_SELECT_BIT = 4;
    localparam int FVRC_CDA_LSB   = 2;
    localparam int FVRC_ADC_LSB   = 0;

    // reset values
    localparam logic [7:0] FVRC_CTRL_RST = 8'h00;
    localparam logic [1:0] FVRC_EVT_RST  = 2'h0;

    // status / enable layout
    localparam int FVRC_EVT_READY = 0;  // reference became ready
    localparam int FVRC_EVT_LOST  = 1;  // ready dropped (disabled)

    // gain selector codes
    localparam logic [1:0] FVRC_GAIN_OFF = 2'h0;
    localparam logic [1:0] FVRC_GAIN_1X  = 2'h1;
    localparam logic [1:0] FVRC_GAIN_2X  = 2'h2;
    localparam logic [1:0] FVRC_GAIN_4X  = 2'h3;

    // settling interval
    localparam int FVRC_CLK_MHZ   = 125;
    localparam int FVRC_SETTLE_US = 25;
    localparam int FVRC_SETTLE_CYC = FVRC_SETTLE_US * FVRC_CLK_MHZ;
    localparam int FVRC_CNT_W     = 16;

    // settle state machine
    typedef enum logic [1:0] {
        FVRC_ST_OFF,
        FVRC_ST_SETTLE,
        FVRC_ST_READY
    } fvrc_state_t;

endpackage

//--- fvrc_amp_if.sv
// interface: one gain amplifier's selector and decoded controls
`timescale 1ns/100ps
`default_nettype none
interface fvrc_amp_if;
    logic [1:0] sel;
    logic       on;
    logic       gain_1x;
    logic       gain_2x;
    logic       gain_4x;
    modport ctl (output sel, input on, gain_1x, gain_2x, gain_4x);
    modport amp (input sel, output on, gain_1x, gain_2x, gain_4x);
endinterface
`default_nettype wire

//--- fvrc_gain_dec.sv
// gain amplifier decoder: registered one-hot gain enables from a 2-bit selector
`timescale 1ns/100ps
`default_nettype none
module fvrc_gain_dec
    import fvrc_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   ref_on_i,
    fvrc_amp_if.amp     amp
);
    logic [3:0] dec_nxt;
    logic [3:0] dec_r;

    // decode selector, gated by reference enable
    always_comb begin
        dec_nxt = 4'h0;
        if (ref_on_i) begin
            case (amp.sel)
                FVRC_GAIN_OFF: dec_nxt = 4'h0;
                FVRC_GAIN_1X:  dec_nxt = 4'h3;
                FVRC_GAIN_2X:  dec_nxt = 4'h5;
                FVRC_GAIN_4X:  dec_nxt = 4'h9;
                default:       dec_nxt = 4'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_r <= 4'h0;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    assign amp.on      = dec_r[0];
    assign amp.gain_1x = dec_r[1];
    assign amp.gain_2x = dec_r[2];
    assign amp.gain_4x = dec_r[3];
endmodule
`default_nettype wire

//--- fvrc_top.sv
// fixed reference control: wishbone registers, settle timer, events, amplifier controls
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - after enabling, wait a settling interval before the reference counts usable
// - ready flag at bit 6 sets once settled; zero when disabled or settling, except always 1 when STD_VARIANT is set
// - adc gain code 00 turns the adc reference output off
// - adc gain code 01 drives the adc reference at 1x
// - adc gain code 10 drives the adc reference at 2x
// - enable bit 1 turns the reference on, 0 turns it off
// - temperature indicator enabled only while its enable bit is 1
// - range bit 1 selects high temperature range, 0 the low range
// - bits 3:2 set comparator/dac/sense gain like the adc selector
module fvrc_top
    import fvrc_pkg::*;
#(
    parameter int  SETTLE_CYC  = FVRC_SETTLE_CYC,
    parameter bit  STD_VARIANT = 1'b0
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o,
    output logic             ref_on_o,
    output logic             ref_ready_o,
    output logic             temp_on_o,
    output logic             temp_high_o,
    output logic             adc_ref_on_o,
    output logic [2:0]       adc_gain_o,
    output logic             cmp_ref_on_o,
    output logic [2:0]       cmp_gain_o
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [6:0]            ctrl_r;      // bits 7,5..0 of control, ready not stored
    logic [6:0]            ctrl_nxt;
    fvrc_state_t           st_r;
    fvrc_state_t           st_nxt;
    logic [FVRC_CNT_W-1:0] cnt_r;
    logic [FVRC_CNT_W-1:0] cnt_nxt;
    logic [1:0]            stat_r;
    logic [1:0]            stat_nxt;
    logic [1:0]            ien_r;
    logic [1:0]            ien_nxt;
    logic                  ack_nxt;
    logic [31:0]           dat_nxt;
    logic                  irq_nxt;
    logic                  rdy_r;
    logic                  rdy_nxt;
    logic                  ref_en;
    logic                  wr_stb;
    logic                  rd_stb;
    logic [1:0]            evt;
    logic [7:0]            ctrl_view;

    fvrc_amp_if adc_amp ();
    fvrc_amp_if cmp_amp ();

    // live control register image with ready flag
    function automatic logic [7:0] ctrl_image(input logic [6:0] c, input logic rdy);
        ctrl_image = {c[6], rdy, c[5:0]};
    endfunction

    assign ref_en    = ctrl_r[6];
    // a write lands at the edge where the master samples ack high
    assign wr_stb    = cyc_i & stb_i & we_i & ack_o & sel_i[0];
    assign rd_stb    = cyc_i & stb_i & ~we_i & ~ack_o;
    assign ctrl_view = ctrl_image(ctrl_r, rdy_r);

    ////////////////////////////////////////////////////////////////////////////
    // settling timer
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            FVRC_ST_OFF: begin
                cnt_nxt = '0;
                if (ref_en) begin
                    st_nxt = FVRC_ST_SETTLE;
                end
            end
            FVRC_ST_SETTLE: begin
                if (!ref_en) begin
                    st_nxt = FVRC_ST_OFF;
                end else if (cnt_r >= FVRC_CNT_W'(SETTLE_CYC - 1)) begin
                    st_nxt = FVRC_ST_READY;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            FVRC_ST_READY: begin
                if (!ref_en) begin
                    st_nxt = FVRC_ST_OFF;
                end
            end
            default: st_nxt = FVRC_ST_OFF;
        endcase
    end

    always_comb begin
        rdy_nxt = STD_VARIANT ? 1'b1 : (st_nxt == FVRC_ST_READY);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r  <= FVRC_ST_OFF;
            cnt_r <= '0;
            rdy_r <= STD_VARIANT;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes and sticky events
    assign evt[FVRC_EVT_READY] = rdy_nxt & ~rdy_r;
    assign evt[FVRC_EVT_LOST]  = ~rdy_nxt & rdy_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        ien_nxt  = ien_r;
        stat_nxt = stat_r;
        if (wr_stb && adr_i == FVRC_CTRL_OFS) begin
            ctrl_nxt = {dat_i[FVRC_EN_BIT], dat_i[5:0]};
        end
        if (wr_stb && adr_i == FVRC_IEN_OFS) begin
            ien_nxt = dat_i[1:0];
        end
        if (wr_stb && adr_i == FVRC_CLR_OFS) begin
            stat_nxt = stat_nxt & ~dat_i[1:0];
        end
        stat_nxt = stat_nxt | evt;  // set wins over clear
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= FVRC_CTRL_RST[6:0];
            ien_r  <= FVRC_EVT_RST;
            stat_r <= FVRC_EVT_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
            ien_r  <= ien_nxt;
            stat_r <= stat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer and interrupt
    always_comb begin
        ack_nxt = cyc_i & stb_i & ~ack_o;  // one-cycle answer to every access
        dat_nxt = 32'h0000_0000;
        if (rd_stb) begin
            case (adr_i)
                FVRC_CTRL_OFS: dat_nxt = {24'h00_0000, ctrl_view};
                FVRC_STAT_OFS: dat_nxt = {30'h0000_0000, stat_r};
                FVRC_IEN_OFS:  dat_nxt = {30'h0000_0000, ien_r};
                default:       dat_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(stat_nxt & ien_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            ack_o <= ack_nxt;
            dat_o <= dat_nxt;
            irq_o <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog controls
    // reference enable, temperature controls and ready output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_on_o    <= 1'b0;
            temp_on_o   <= 1'b0;
            temp_high_o <= 1'b0;
            ref_ready_o <= STD_VARIANT;
        end else begin
            ref_on_o    <= ctrl_r[6];
            temp_on_o   <= ctrl_r[FVRC_TEMP_INDICATOR_ENABLE_BIT];
            temp_high_o <= ctrl_r[FVRC_TEMP_RANGE_SELECT_BIT];
            ref_ready_o <= rdy_r;
        end
    end

    assign adc_amp.sel = ctrl_r[FVRC_ADC_LSB +: 2];
    assign cmp_amp.sel = ctrl_r[FVRC_CDA_LSB +: 2];

    fvrc_gain_dec u_adc_dec (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ref_on_i (ref_en),
        .amp      (adc_amp)
    );

    fvrc_gain_dec u_cmp_dec (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ref_on_i (ref_en),
        .amp      (cmp_amp)
    );

    assign adc_ref_on_o = adc_amp.on;
    assign adc_gain_o   = {adc_amp.gain_4x, adc_amp.gain_2x, adc_amp.gain_1x};
    assign cmp_ref_on_o = cmp_amp.on;
    assign cmp_gain_o   = {cmp_amp.gain_4x, cmp_amp.gain_2x, cmp_amp.gain_1x};

endmodule
`default_nettype wire

//--- fvrc_top_sva.sv
// checker: port assertions for the fixed reference control block
`timescale 1ns/100ps
`default_nettype none
module fvrc_top_chk
    import fvrc_pkg::*;
#(
    parameter int SETTLE_CYC  = FVRC_SETTLE_CYC,
    parameter bit STD_VARIANT = 1'b0
)(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    input wire logic        irq_o,
    input wire logic        ref_on_o,
    input wire logic        ref_ready_o,
    input wire logic        temp_on_o,
    input wire logic        temp_high_o,
    input wire logic        adc_ref_on_o,
    input wire logic [2:0]  adc_gain_o,
    input wire logic        cmp_ref_on_o,
    input wire logic [2:0]  cmp_gain_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr;
    int   on_cnt_r;
    int   on_cnt_nxt;
    // accepted control write, seen at the ack edge
    assign wr = cyc_i && stb_i && we_i && ack_o && adr_i == FVRC_CTRL_OFS && sel_i[0];
    // cycles the reference has been on, saturating
    always_comb on_cnt_nxt = !ref_on_o ? 0 : (on_cnt_r > 1000 ? on_cnt_r : on_cnt_r + 1);
    always_ff @(posedge clk_i) on_cnt_r <= rst_i ? 0 : on_cnt_nxt;
    function automatic logic [3:0] amp(input logic en, input logic [1:0] c);
        return (en && c != 2'h0) ? {1'b1, 3'(3'h1 << (c - 2'h1))} : 4'h0;
    endfunction
    ////////////////////////////////////////
    // enable follows write
    property p_en; wr |-> ##2 ref_on_o == $past(dat_i[FVRC_EN_BIT], 2); endproperty
    a_en: assert property (p_en) else $error("reference enable wrong");
    property p_temp; wr |-> ##2 {temp_on_o, temp_high_o} == $past(dat_i[5:4], 2); endproperty
    a_temp: assert property (p_temp) else $error("temperature controls wrong");
    property p_adc; wr |-> ##2 {adc_ref_on_o, adc_gain_o} == amp($past(dat_i[7], 2), $past(dat_i[1:0], 2)); endproperty
    a_adc: assert property (p_adc) else $error("converter gain wrong");
    property p_cmp; wr |-> ##2 {cmp_ref_on_o, cmp_gain_o} == amp($past(dat_i[7], 2), $past(dat_i[3:2], 2)); endproperty
    a_cmp: assert property (p_cmp) else $error("comparator gain wrong");
    property p_rst; $fell(rst_i) |-> !ref_on_o && !temp_on_o && !temp_high_o && !adc_ref_on_o
        && !cmp_ref_on_o && adc_gain_o == 3'h0 && cmp_gain_o == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("controls not cleared by reset");
    property p_rdy_on; ref_ready_o && !STD_VARIANT |-> $past(ref_on_o); endproperty
    a_rdy_on: assert property (p_rdy_on) else $error("ready while disabled");
    property p_settle; $rose(ref_ready_o) && !STD_VARIANT |-> on_cnt_r >= SETTLE_CYC - 2; endproperty
    a_settle: assert property (p_settle) else $error("ready before settling");
    property p_done; on_cnt_r == SETTLE_CYC + 6 |-> ref_ready_o; endproperty
    a_done: assert property (p_done) else $error("ready missing after settling");
    property p_std; STD_VARIANT |-> ref_ready_o; endproperty
    a_std: assert property (p_std) else $error("standard variant not ready");
    c_ready: cover property ($rose(ref_ready_o));
    c_irq: cover property ($rose(irq_o));
    c_wr: cover property (wr ##2 adc_ref_on_o);
endmodule
bind fvrc_top fvrc_top_chk #(.SETTLE_CYC(SETTLE_CYC), .STD_VARIANT(STD_VARIANT)) i_chk (.*);
`default_nettype wire

//--- tb_fvrc_top.sv
// testbench: fixed reference control registers, amplifiers, settling and events
`timescale 1ns/100ps
`default_nettype none
module tb_fvrc_top
    import fvrc_pkg::*;
;
    localparam int SC = 8;  // shortened settling count
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic [2:0]  adc_gain_o, cmp_gain_o;
    logic        ack_o, irq_o, ref_on_o, ref_ready_o, temp_on_o, temp_high_o;
    logic        adc_ref_on_o, cmp_ref_on_o, std_ready;
    int          errors = 0, checks_done = 0, cyc_n = 0, m_ctl = 0, n;
    wire logic [10:0] pins = {ref_on_o, temp_on_o, temp_high_o, adc_ref_on_o, adc_gain_o, cmp_ref_on_o, cmp_gain_o};
    fvrc_top #(.SETTLE_CYC(SC), .STD_VARIANT(1'b0)) i_fvrc_top (.*);
    fvrc_top #(.SETTLE_CYC(SC), .STD_VARIANT(1'b1)) i_fvrc_top_std (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o(), .ack_o(), .irq_o(), .ref_on_o(), .ref_ready_o(std_ready),
        .temp_on_o(), .temp_high_o(), .adc_ref_on_o(), .adc_gain_o(), .cmp_ref_on_o(), .cmp_gain_o());
    always #4 clk_i = ~clk_i;
    ////////////////////////////////////////
    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            errors++;
            wrap_up;
        end
    end
    task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected read at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected pins at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    // one classic wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'hf);
        chk_rd(q, e);
    endtask
    // expected {on, one-hot gain} of one amplifier
    function automatic logic [3:0] amp(input int sh);
        logic [1:0] c = 2'((m_ctl >> sh) & 3);
        return (m_ctl[7] && c != 2'h0) ? {1'b1, 3'(3'h1 << (c - 2'h1))} : 4'h0;
    endfunction
    task automatic setc(input logic [7:0] d);
        wr(FVRC_CTRL_OFS, d);
        m_ctl = d & 8'hbf;
        repeat (2) @(posedge clk_i);
        chk_pin(pins, {m_ctl[7], m_ctl[5:4], amp(0), amp(2)});
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h39f59f2b));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, refused and unmapped accesses
        rd(FVRC_CTRL_OFS, 32'h0);
        rd(FVRC_IEN_OFS, 32'h0);
        wr(4'h2, 8'hff);
        wr(FVRC_STAT_OFS, 8'hff);
        bus(1'b1, FVRC_CTRL_OFS, 8'hbf, 4'he);
        rd(4'h2, 32'h0);
        rd(FVRC_STAT_OFS, 32'h0);
        rd(FVRC_CTRL_OFS, 32'h0);
        chk_pin(std_ready, 1'b1);
        // random fields with the reference off
        for (int i = 0; i < 12; i++) begin
            setc(8'($urandom) & 8'h7f);
            rd(FVRC_CTRL_OFS, m_ctl);
        end
        // every gain code on both amplifiers
        for (int i = 0; i < 16; i++)
            setc(8'h80 | 8'(i) | (8'($urandom) & 8'h30));
        setc(8'h00);
        wr(FVRC_CLR_OFS, 8'h03);
        wr(FVRC_IEN_OFS, 8'h03);
        rd(FVRC_STAT_OFS, 32'h0);
        // settling, ready flag and its event
        wr(FVRC_CTRL_OFS, 8'h80);
        rd(FVRC_CTRL_OFS, 32'h80);
        n = 3;
        while (ref_ready_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk_pin(n >= SC && n <= SC + 6, 1'b1);
        rd(FVRC_CTRL_OFS, 32'hc0);
        rd(FVRC_STAT_OFS, 32'h1);
        chk_pin(irq_o, 1'b1);
        wr(FVRC_CLR_OFS, 8'h01);
        rd(FVRC_STAT_OFS, 32'h0);
        chk_pin(irq_o, 1'b0);
        // disable, lost event masked then cleared
        setc(8'h00);
        rd(FVRC_CTRL_OFS, 32'h0);
        rd(FVRC_STAT_OFS, 32'h2);
        chk_pin(irq_o, 1'b1);
        wr(FVRC_IEN_OFS, 8'h01);
        rd(FVRC_IEN_OFS, 32'h1);
        chk_pin(irq_o, 1'b0);
        wr(FVRC_CLR_OFS, 8'h03);
        rd(FVRC_CLR_OFS, 32'h0);
        rd(FVRC_STAT_OFS, 32'h0);
        // reset in mid-run
        setc(8'hbd);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd(FVRC_CTRL_OFS, 32'h0);
        chk_pin(pins, 11'h0);
        chk_pin(std_ready, 1'b1);
        wrap_up;
    end
endmodule
`default_nettype wire
